// file: bench/test_vtm_ctrl.sv
// Purpose: Self-checking bench for the voltage trip monitor control block
// Assumes: Zero or more wait states, single word transfers only
// Notes: Expected values come from the field layout, not from the block
`timescale 1ns/100ps
`default_nettype none
module test_vtm_ctrl;
    import vtm_pkg::*;
    logic hclk, hresetn, hsel, hwrite, bg_good, ext_hi;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, cmp_a, bg_a, men, dir, ext_sel, irq;
    logic [3:0] lvl, volt_code;
    int num_errors = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    vtm_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmp_above_async(cmp_a), .bandgap_ok_async(bg_a),
        .monitor_enable(men), .trip_direction_select(dir), .trip_level(lvl),
        .external_sense_select(ext_sel), .irq(irq));
    vtm_analog_model ana_u (.hclk(hclk), .monitor_enable(men), .trip_level(lvl), .volt_code(volt_code),
        .ext_hi(ext_hi), .bg_good(bg_good), .cmp_above_async(cmp_a), .bandgap_ok_async(bg_a));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 40 ns; initial input values are set with the reset below
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic tally_and_finish;
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_word(nm, {31'h0, e}, {31'h0, g});
    endtask : cmp_bit
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle
    // One AHB single transfer; the address phase holds until hready is seen
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rd);
        cmp_word(nm, e, rd);
    endtask : rd_chk
    // Watchdog sized well past two settling periods
    initial
    begin
        #(5000 * 40);
        num_errors++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {bg_good, ext_hi} = 2'b00;
        volt_code = 4'h5;
        idle(8);
        hresetn <= 1'b1;
        rd_chk("ctrl_reset", ADDR_CTRL, 32'h0);
        rd_chk("status_reset", ADDR_STATUS, 32'h0);
        rd_chk("ien_reset", ADDR_IEN, 32'h0);
        bg_good <= 1'b1;
        idle(4);
        // Every level code with the monitor off; comparator wanders meanwhile
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_CTRL, 32'(i));
            rd_chk("ctrl_level", ADDR_CTRL, 32'(i) | 32'h40);
            cmp_word("trip_level", 32'(i), {28'h0, lvl});
            cmp_bit("ext_sel", i == 15, ext_sel);
            cmp_bit("enable_off", 1'b0, men);
        end
        rd_chk("status_off", ADDR_STATUS, 32'h0);
        // Read-only status bits ignore writes; enabling starts the settling time
        wr(ADDR_CTRL, 32'hFF);
        rd_chk("ctrl_ro", ADDR_CTRL, 32'hDF);
        cmp_bit("enable_on", 1'b1, men);
        cmp_bit("dir_out", 1'b1, dir);
        wr(ADDR_CTRL, 32'h1A);
        idle(int'(STAB_CYCLES) - 80);
        rd_chk("ref_settling", ADDR_CTRL, 32'h5A);
        rd_chk("no_evt_settling", ADDR_STATUS, 32'h0);
        idle(100);
        rd_chk("ref_stable", ADDR_CTRL, 32'h7A);
        rd_chk("fall_evt", ADDR_STATUS, 32'h1);
        cmp_bit("irq_masked", 1'b0, irq);
        wr(ADDR_IEN, 32'h1);
        idle(2);
        cmp_bit("irq_on", 1'b1, irq);
        rd_chk("ien_rb", ADDR_IEN, 32'h1);
        // Flag holds after the voltage recovers, until software clears it
        volt_code <= 4'hC;
        idle(6);
        rd_chk("sticky", ADDR_STATUS, 32'h1);
        wr(ADDR_CLEAR, 32'h1);
        rd_chk("cleared", ADDR_STATUS, 32'h0);
        rd_chk("clear_rd", ADDR_CLEAR, 32'h0);
        cmp_bit("irq_off", 1'b0, irq);
        wr(ADDR_CTRL, 32'h9A);
        idle(6);
        rd_chk("rise_evt", ADDR_STATUS, 32'h1);
        cmp_bit("irq_rise", 1'b1, irq);
        // Enable gates the output; a clear during a live trip loses to the set
        wr(ADDR_IEN, 32'h0);
        idle(1);
        cmp_bit("irq_gated", 1'b0, irq);
        wr(ADDR_IEN, 32'h1);
        wr(ADDR_CLEAR, 32'h1);
        rd_chk("set_wins", ADDR_STATUS, 32'h1);
        volt_code <= 4'h5;
        idle(6);
        wr(ADDR_CLEAR, 32'h1);
        rd_chk("rise_none", ADDR_STATUS, 32'h0);
        // External sense code follows the sense pin instead of the supply
        wr(ADDR_CTRL, 32'h9F);
        idle(6);
        rd_chk("ext_quiet", ADDR_STATUS, 32'h0);
        cmp_bit("ext_sel_on", 1'b1, ext_sel);
        ext_hi <= 1'b1;
        idle(6);
        rd_chk("ext_evt", ADDR_STATUS, 32'h1);
        // Off means no events; every new enabling settles again
        wr(ADDR_CTRL, 32'h0A);
        wr(ADDR_CLEAR, 32'h1);
        idle(20);
        rd_chk("off_none", ADDR_STATUS, 32'h0);
        volt_code <= 4'hC;
        wr(ADDR_CTRL, 32'h9A);
        idle(10);
        rd_chk("resettle", ADDR_CTRL, 32'hDA);
        rd_chk("resettle_evt", ADDR_STATUS, 32'h0);
        // Unmapped place reads zero and ignores writes
        wr(32'h0000_3E40, 32'hFFFF_FFFF);
        rd_chk("unmapped", 32'h0000_3E40, 32'h0);
        cmp_bit("hresp", 1'b0, hresp);
        cmp_bit("hreadyout", 1'b1, hreadyout);
        tally_and_finish();
    end
endmodule : test_vtm_ctrl
`default_nettype wire

// file: bench/vtm_analog_model.sv
// Purpose: Stand-in for the analogue comparator and bandgap
// Assumes: Supply voltage and trip point given as level codes
// Notes: An unpowered comparator wanders every cycle
`timescale 1ns/100ps
`default_nettype none
module vtm_analog_model (
    input wire logic hclk,
    input wire logic monitor_enable,
    input wire logic [3:0] trip_level,
    input wire logic [3:0] volt_code,
    input wire logic ext_hi,
    input wire logic bg_good,
    output logic cmp_above_async,
    output logic bandgap_ok_async
);
    logic wander_q = 1'b0;
    // Off means no defined output level, so make it move every cycle
    always @(posedge hclk) wander_q <= ~wander_q;
    // High when the sensed level is at or above the trip point
    always_comb
    begin
        if (!monitor_enable) cmp_above_async = wander_q;
        else if (trip_level == 4'hF) cmp_above_async = ext_hi;
        else cmp_above_async = (volt_code >= trip_level);
    end
    assign bandgap_ok_async = bg_good;
endmodule : vtm_analog_model
`default_nettype wire

// file: core/vtm_ctrl.sv
// Purpose: AHB-Lite register front end and event logic of the voltage trip monitor
// Assumes: Analogue comparator and bandgap outside, asynchronous to hclk
// Notes: Zero wait states, OKAY always; unmapped reads return zero
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module vtm_ctrl
    import vtm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cmp_above_async,
    input wire logic bandgap_ok_async,
    output logic monitor_enable,
    output logic trip_direction_select,
    output logic [3:0] trip_level,
    output logic external_sense_select,
    output logic irq
);
    vtm_mon_if mon ();

    logic wr_pend_q;
    logic wr_pend_d;
    logic [31:0] wr_addr_q;
    logic [31:0] wr_addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic evt_q;
    logic evt_d;
    logic ien_q;
    logic ien_d;
    logic irq_q;
    logic irq_d;
    logic addr_phase;
    logic evt_cond;
    logic evt_clear;

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Merge a written byte into control; read-only bits stay clear in storage
    function automatic logic [7:0] ctrl_merge(input logic [7:0] old_v, input logic [7:0] wr_v);
        ctrl_merge = (old_v & ~CTRL_WR_MASK) | (wr_v & CTRL_WR_MASK);
    endfunction : ctrl_merge

    // Read view of one register; live status bits fill positions 6 and 5
    function automatic logic [31:0] rd_word(
        input logic [31:0] addr,
        input logic [7:0] ctrl_v,
        input logic bg_v,
        input logic ref_v,
        input logic evt_v,
        input logic ien_v
    );
        logic [7:0] view;
        view = ctrl_v & CTRL_WR_MASK;
        view[CTRL_BG_BIT] = bg_v;
        view[CTRL_REF_BIT] = ref_v;
        rd_word = 32'h0000_0000;
        case (addr)
            ADDR_CTRL: rd_word = {24'h00_0000, view};
            ADDR_STATUS: rd_word = {31'h0000_0000, evt_v};
            ADDR_IEN: rd_word = {31'h0000_0000, ien_v};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////
    // Analogue side: synchroniser and settling timer

    vtm_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .cmp_above_async(cmp_above_async),
        .bandgap_ok_async(bandgap_ok_async),
        .mon(mon.sync)
    );

    vtm_settle u_settle (
        .hclk(hclk),
        .hresetn(hresetn),
        .mon(mon.timer)
    );

    ////////////////////////////////////////////////////////////////
    // Bus address phase and pending write

    // Only full words are meaningful; hsize is not checked, narrower writes land in low bits
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

    always_comb
    begin
        wr_pend_d = addr_phase && hwrite;
        wr_addr_d = addr_phase ? haddr : wr_addr_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control and interrupt enable registers

    always_comb
    begin
        ctrl_d = ctrl_q;
        ien_d = ien_q;
        if (wr_pend_q && (wr_addr_q == ADDR_CTRL))
            ctrl_d = ctrl_merge(ctrl_q, hwdata[7:0]);
        if (wr_pend_q && (wr_addr_q == ADDR_IEN))
            ien_d = hwdata[STATUS_EVT_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= CTRL_RESET;
            ien_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            ien_q <= ien_d;
        end
    end

    assign mon.enable = ctrl_q[CTRL_EN_BIT];

    ////////////////////////////////////////////////////////////////
    // Trip detection; level sensitive, so a persisting excursion re-sets after a clear

    always_comb
    begin
        evt_cond = 1'b0;
        if (ctrl_q[CTRL_EN_BIT] && mon.ref_stable)
        begin
            if (ctrl_q[CTRL_DIR_BIT])
                evt_cond = mon.cmp_above_s;
            else
                evt_cond = !mon.cmp_above_s;
        end
    end

    // Set beats clear so an excursion during the clear write is kept
    assign evt_clear = wr_pend_q && (wr_addr_q == ADDR_CLEAR) && hwdata[STATUS_EVT_BIT];

    always_comb
    begin
        evt_d = (evt_q && !evt_clear) || evt_cond;
        irq_d = evt_d && ien_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            evt_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            evt_q <= evt_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data; uses next values so a write just before a read is seen

    always_comb
    begin
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite)
            hrdata_d = rd_word(haddr, ctrl_d, mon.bandgap_s, mon.ref_stable, evt_d, ien_d);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else
            hrdata_q <= hrdata_d;
    end

    ////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign monitor_enable = ctrl_q[CTRL_EN_BIT];
    assign trip_direction_select = ctrl_q[CTRL_DIR_BIT];
    assign trip_level = ctrl_q[3:0];
    assign external_sense_select = (ctrl_q[3:0] == LEVEL_EXTERNAL);
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////
    // Checks

    // Upper bound for settling, two cycles of margin past the timer
    localparam int CHK_STAB_MAX = int'(STAB_CYCLES) + 2;

    // All checks run on hclk and sleep while reset is held
    default clocking chk_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_ctrl_write;
        wr_pend_q && (wr_addr_q == ADDR_CTRL);
    endsequence

    sequence s_enable_settled;
        ($rose(mon.enable) && mon.bandgap_s) ##1 (mon.bandgap_s && mon.enable) [*8];
    endsequence

    sequence s_fall_armed;
        mon.enable && mon.ref_stable && !trip_direction_select && !mon.cmp_above_s;
    endsequence

    sequence s_rise_armed;
        mon.enable && mon.ref_stable && trip_direction_select && mon.cmp_above_s;
    endsequence

    chk_fall_event_sets:
    assert property (s_fall_armed |=> evt_q)
        else $error("fall below trip did not set event flag");

    chk_rise_event_sets:
    assert property (s_rise_armed |=> evt_q)
        else $error("rise above trip did not set event flag");

    chk_flag_needs_ref:
    assert property ($rose(evt_q) |-> $past(mon.ref_stable) && $past(monitor_enable))
        else $error("event flag set without stable reference");

    chk_disabled_quiet:
    assert property (!monitor_enable && !evt_q |=> !evt_q)
        else $error("event flag set while monitor disabled");

    chk_ref_low_settling:
    assert property (s_enable_settled |-> !mon.ref_stable)
        else $error("reference stable too early after enable");

    chk_ref_rises_bound:
    assert property ($rose(mon.enable) ##0 (mon.enable && mon.bandgap_s) [*8]
        |-> ##[1:CHK_STAB_MAX] (mon.ref_stable || !mon.enable || !mon.bandgap_s))
        else $error("reference stable never reached after enable");

    chk_flag_sticky:
    assert property (evt_q && !evt_clear |=> evt_q)
        else $error("event flag dropped without clear");

    chk_irq_gating:
    assert property (irq == (evt_q && ien_q))
        else $error("interrupt output not gated by enable");

    chk_ctrl_write_out:
    assert property (s_ctrl_write |=> trip_level == $past(hwdata[3:0])
        && monitor_enable == $past(hwdata[CTRL_EN_BIT]))
        else $error("control write not reflected on outputs");

    chk_bandgap_read:
    assert property (addr_phase && !hwrite && haddr == ADDR_CTRL
        |=> hrdata[CTRL_BG_BIT] == $past(mon.bandgap_s))
        else $error("bandgap status bit wrong on read");

    ////////////////////////////////////////////////////////////////
    // Further checks on reads, clears and register stability

    // A read of control; the word appears one edge later
    sequence s_ctrl_read;
        addr_phase && !hwrite && (haddr == ADDR_CTRL);
    endsequence

    sequence s_status_read;
        addr_phase && !hwrite && (haddr == ADDR_STATUS);
    endsequence

    // A clear write that meets no live trip condition
    sequence s_quiet_clear;
        evt_clear && !evt_cond;
    endsequence

    chk_ref_bit_read:
    assert property (s_ctrl_read |=> hrdata[CTRL_REF_BIT] == $past(mon.ref_stable))
        else $error("reference stable bit wrong on read");

    chk_status_read:
    assert property (s_status_read |=> hrdata[STATUS_EVT_BIT] == evt_q)
        else $error("status read does not show event flag");

    chk_clear_drops:
    assert property (s_quiet_clear |=> !evt_q)
        else $error("clear write left event flag set");

    // Set wins, otherwise a persisting excursion could be lost between clears
    chk_set_beats_clear:
    assert property (evt_clear && evt_cond |=> evt_q)
        else $error("clear won over a simultaneous trip");

    chk_ref_drops_off:
    assert property (!mon.enable |=> !mon.ref_stable)
        else $error("reference stable held while disabled");

    // Control outputs only move on a control write
    chk_ctrl_holds:
    assert property (!(wr_pend_q && (wr_addr_q == ADDR_CTRL)) |=> $stable(monitor_enable)
        && $stable(trip_direction_select) && $stable(trip_level))
        else $error("control outputs changed without a write");

    chk_dir_write:
    assert property (s_ctrl_write |=> trip_direction_select == $past(hwdata[CTRL_DIR_BIT]))
        else $error("direction write not reflected on output");

    chk_ext_select:
    assert property (s_ctrl_write |=> external_sense_select == ($past(hwdata[3:0]) == LEVEL_EXTERNAL))
        else $error("external sense select wrong after write");

    chk_irq_needs_ien:
    assert property (!ien_q |-> !irq)
        else $error("interrupt raised with enable clear");
endmodule : vtm_ctrl
`default_nettype wire

// file: core/vtm_settle.sv
// Purpose: Settling timer that raises reference-stable after enabling
// Assumes: Bandgap indication already synchronised
// Notes: Restarts from zero on every disable
`timescale 1ns/100ps
`default_nettype none
module vtm_settle
    import vtm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    vtm_mon_if.timer mon
);
    logic [STAB_CNT_W-1:0] cnt_q;
    logic [STAB_CNT_W-1:0] cnt_d;

    ////////////////////////////////////////////////////////////////
    // Count only while powered and the bandgap is good; saturate at the end
    always_comb
    begin
        cnt_d = cnt_q;
        if (!mon.enable || !mon.bandgap_s)
            cnt_d = '0;
        else if (cnt_q != STAB_CYCLES)
            cnt_d = cnt_q + STAB_CNT_W'(1);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign mon.ref_stable = (cnt_q == STAB_CYCLES);
endmodule : vtm_settle
`default_nettype wire

// file: core/vtm_sync.sv
// Purpose: Two-flop synchroniser for the analogue indications
// Assumes: Raw inputs may change at any time
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module vtm_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cmp_above_async,
    input wire logic bandgap_ok_async,
    vtm_mon_if.sync mon
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;

    ////////////////////////////////////////////////////////////////
    // Metastability guard before any comparison is made
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end
        else
        begin
            meta_q <= {bandgap_ok_async, cmp_above_async};
            sync_q <= meta_q;
        end
    end

    assign mon.cmp_above_s = sync_q[0];
    assign mon.bandgap_s = sync_q[1];
endmodule : vtm_sync
`default_nettype wire

// file: shared/vtm_mon_if.sv
// Purpose: Carrier between the monitor core, synchroniser and settling timer
// Assumes: One clock domain after synchronisation
// Notes: Comparator high means the voltage is at or above the trip point
`timescale 1ns/100ps
`default_nettype none
interface vtm_mon_if;
    logic cmp_above_s;
    logic bandgap_s;
    logic enable;
    logic ref_stable;
    modport sync (output cmp_above_s, output bandgap_s);
    modport timer (input enable, input bandgap_s, output ref_stable);
    modport core (input cmp_above_s, input bandgap_s, input ref_stable, output enable);
endinterface : vtm_mon_if
`default_nettype wire

// file: shared/vtm_pkg.sv
// Purpose: Constants for the voltage trip monitor control block
// Assumes: hclk at 25 MHz, AHB-Lite word registers
// Notes: Notes on behaviour below
// Notes on behaviour
// - A crossing of the trip point in the chosen direction sets the monitor event flag.
// - Direction bit 7 clear means falling to or below the trip point is the event, set means rising to or above; clear flags only below here.
// - The analogue monitor is powered only while enable bit 4 is set, and that bit resets to zero.
// - After every enabling, reference-stable bit 5 reads low until the settling time has passed, then high.
// - No event flag may be set before the reference-stable bit is high.
// - Read-only bit 6 shows whether the bandgap reference is stable.
// - Trip level bits 3 to 0 pick the trip point, 1110 highest, 1000 lowest, 1111 the external sense pin; the bench model takes 0000 as the lowest.
// - With enable clear the detector is off and produces no events.
// - A set event flag reaches the interrupt output only while its interrupt enable is set.
package vtm_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [11:0] IDX_CTRL = 12'hF85;
    localparam logic [11:0] IDX_STATUS = 12'hF86;
    localparam logic [11:0] IDX_CLEAR = 12'hF87;
    localparam logic [11:0] IDX_IEN = 12'hF88;
    localparam logic [31:0] ADDR_CTRL = {18'h00000, IDX_CTRL, 2'b00};
    localparam logic [31:0] ADDR_STATUS = {18'h00000, IDX_STATUS, 2'b00};
    localparam logic [31:0] ADDR_CLEAR = {18'h00000, IDX_CLEAR, 2'b00};
    localparam logic [31:0] ADDR_IEN = {18'h00000, IDX_IEN, 2'b00};
    // Control field positions
    localparam int CTRL_DIR_BIT = 7;
    localparam int CTRL_BG_BIT = 6;
    localparam int CTRL_REF_BIT = 5;
    localparam int CTRL_EN_BIT = 4;
    localparam logic [7:0] CTRL_WR_MASK = 8'h9F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
    localparam int STATUS_EVT_BIT = 0;
    // Settling time after enabling, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int STAB_TIME_NS = 20000;
    localparam int STAB_CNT_W = 10;
    localparam logic [STAB_CNT_W-1:0] STAB_CYCLES =
        STAB_CNT_W'((STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : vtm_pkg
